// File: common/ewsp_pkg.sv
package ewsp_pkg;
  // bus and field widths
  localparam int EWSP_AW = 16;
  localparam int EWSP_XAW = 20;
  localparam int EWSP_PGW = 4;
  localparam int EWSP_FW = 3;
  localparam int EWSP_CW = 4;
  // memory-mapped register addresses in data space
  localparam logic [15:0] EWSP_PAGE_OFS = 16'h001E;
  localparam logic [15:0] EWSP_WSEL_OFS = 16'h0028;
  localparam logic [15:0] EWSP_WCTL_OFS = 16'h002B;
  // reset values: seven waits in every range, no doubling, page zero
  localparam logic [15:0] EWSP_WSEL_RST = 16'h7FFF;
  localparam logic [15:0] EWSP_WCTL_RST = 16'h0000;
  localparam logic [3:0] EWSP_PAGE_RST = 4'h0;
  localparam logic [15:0] EWSP_ZERO16 = 16'h0000;
  localparam logic [3:0] EWSP_ZERO4 = 4'h0;
  // wait-select field positions
  localparam int EWSP_XPA_BIT = 15;
  localparam int EWSP_IO_LSB = 12;
  localparam int EWSP_DHI_LSB = 9;
  localparam int EWSP_DLO_LSB = 6;
  localparam int EWSP_PHI_LSB = 3;
  localparam int EWSP_PLO_LSB = 0;
  localparam int EWSP_FIELDS_MSB = 14;
  localparam int EWSP_DBL_BIT = 0;
  // address decode
  localparam int EWSP_HALF_BIT = 15;
  localparam logic [1:0] EWSP_OVL_TOP = 2'h0;
  localparam logic [15:0] EWSP_DATA_INT_LIM = 16'h4000;
  localparam logic [3:0] EWSP_WAIT_MAX = 4'hE;

  typedef enum logic [1:0] {EWSP_SP_PROG, EWSP_SP_DATA, EWSP_SP_IO} ewsp_space_e;

  function automatic logic [2:0] ewsp_field(input logic [15:0] sel, input int lsb);
    ewsp_field = sel[lsb +: EWSP_FW];
  endfunction : ewsp_field

  // selected base count, optionally doubled
  function automatic logic [3:0] ewsp_waits(input logic [15:0] sel, input logic dbl,
                                            input ewsp_space_e sp, input logic hi_half);
    logic [2:0] base;
    base = ewsp_field(sel, EWSP_PLO_LSB);
    case (sp)
      EWSP_SP_IO: base = ewsp_field(sel, EWSP_IO_LSB);
      EWSP_SP_DATA: base = hi_half ? ewsp_field(sel, EWSP_DHI_LSB) : ewsp_field(sel, EWSP_DLO_LSB);
      default: begin
        if (!sel[EWSP_XPA_BIT] && hi_half) begin
          base = ewsp_field(sel, EWSP_PHI_LSB);
        end
      end
    endcase
    ewsp_waits = dbl ? {base, 1'b0} : {1'b0, base};
  endfunction : ewsp_waits
endpackage : ewsp_pkg

// File: rtl/ewsp_sync2.sv
`timescale 1ns/1ps
module ewsp_sync2 (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic din,
  output logic dout
);
  logic meta;

  // two-stage synchroniser for an asynchronous pin
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : ewsp_sync2

// File: rtl/ewsp_wait_timer.sv
`timescale 1ns/1ps
module ewsp_wait_timer
  import ewsp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic gate_on,
  input wire logic load,
  input wire logic [EWSP_CW-1:0] load_val,
  output logic expired
);
  logic [EWSP_CW-1:0] cnt;

  // down counter; frozen while its clock is gated off, which saves power
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= EWSP_ZERO4;
    end else if (load) begin
      cnt <= load_val;
    end else if (gate_on && cnt != EWSP_ZERO4) begin
      cnt <= cnt - 4'h1;
    end
  end

  assign expired = (cnt == EWSP_ZERO4);
endmodule : ewsp_wait_timer

// File: rtl/ewsp_top.sv
// Functional notes
// - each external cycle stretches by programmed waits, never more than fourteen.
// - all wait fields zero switches the wait generator clock off.
// - wait select low fifteen bits hold five three-bit base counts.
// - after reset every external range gets seven wait states.
// - bits 14..12 time every I/O access.
// - bits 11..9 time external data accesses in upper data half.
// - bits 8..6 time external data accesses in lower data half.
// - extended bit clear, bits 5..3 time upper half of any page.
// - extended bit clear, bits 2..0 time lower half of any page.
// - extended bit set, bits 2..0 time all program space, 5..3 ignored.
// - doubler bit doubles base counts when set; resets to zero.
// - wait control bits 15..1 read zero and ignore writes.
// - twenty program address lines, sixteen pages of 64K words.
// - page register at data address 001Eh, cleared by reset.
// - far branch, call and return, and software writes to 001Eh, change the page register.
// - table read and write form a twenty-bit address from the accumulator.
// - overlay set maps lower 16K of every page to on-chip RAM.
// - on-chip RAM at data 0080h..3FFFh, in program space only with overlay.
`timescale 1ns/1ps
module ewsp_top
  import ewsp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ewsp_pkg::EWSP_AW-1:0] mmr_addr,
  input wire logic mmr_wr,
  input wire logic mmr_rd,
  input wire logic [15:0] mmr_wdata,
  output logic [15:0] mmr_rdata,
  input wire logic ram_overlay_bit,
  input wire logic far_load,
  input wire logic [ewsp_pkg::EWSP_PGW-1:0] far_page,
  input wire logic acc_req,
  input wire ewsp_pkg::ewsp_space_e acc_space,
  input wire logic [ewsp_pkg::EWSP_AW-1:0] acc_addr,
  input wire logic acc_we,
  input wire logic acc_table,
  input wire logic [ewsp_pkg::EWSP_XAW-1:0] acc_xaddr,
  output logic acc_busy,
  output logic acc_done,
  output logic acc_internal,
  output logic [ewsp_pkg::EWSP_PGW-1:0] prog_page,
  output logic [ewsp_pkg::EWSP_XAW-1:0] ext_addr,
  output ewsp_pkg::ewsp_space_e ext_space,
  output logic ext_strb_n,
  output logic ext_we_n,
  input wire logic ext_ready,
  output logic wsg_clk_on
);
  import ewsp_pkg::*;

  typedef enum logic [1:0] {EWSP_IDLE, EWSP_WAIT, EWSP_INT} ewsp_state_e;

  ewsp_state_e state;
  ewsp_state_e next_state;
  logic [15:0] wait_sel;
  logic wait_count_doubler;
  logic ready_s;
  logic expired;
  logic take;
  logic [EWSP_XAW-1:0] next_xaddr;
  logic next_internal;
  logic [EWSP_CW-1:0] next_waits;
  logic fields_zero;
  logic [15:0] rd_mux;

  assign take = acc_req && (state == EWSP_IDLE);
  assign fields_zero = (wait_sel[EWSP_FIELDS_MSB:0] == 15'h0000);

  // ready pin comes from off chip, so it is synchronised first
  ewsp_sync2 u_rdy_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din(ext_ready),
    .dout(ready_s)
  );

  // the wait counter only ticks while its gated clock is running
  ewsp_wait_timer u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .gate_on(wsg_clk_on),
    .load(take),
    .load_val(next_waits),
    .expired(expired)
  );

  // program page register, written by software or a far transfer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prog_page <= EWSP_PAGE_RST;
    end else if (far_load) begin
      prog_page <= far_page;
    end else if (mmr_wr && mmr_addr == EWSP_PAGE_OFS) begin
      prog_page <= mmr_wdata[EWSP_PGW-1:0];
    end
  end

  // wait select register; reset gives seven waits in every range
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_sel <= EWSP_WSEL_RST;
    end else if (mmr_wr && mmr_addr == EWSP_WSEL_OFS) begin
      wait_sel <= mmr_wdata;
    end
  end

  // wait control: only the doubler bit is stored, the rest is reserved
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_count_doubler <= EWSP_WCTL_RST[EWSP_DBL_BIT];
    end else if (mmr_wr && mmr_addr == EWSP_WCTL_OFS) begin
      wait_count_doubler <= mmr_wdata[EWSP_DBL_BIT];
    end
  end

  // register read mux; unmapped addresses read as zero
  always_comb begin
    rd_mux = EWSP_ZERO16;
    case (mmr_addr)
      EWSP_PAGE_OFS: rd_mux[EWSP_PGW-1:0] = prog_page;
      EWSP_WSEL_OFS: rd_mux = wait_sel;
      EWSP_WCTL_OFS: rd_mux[EWSP_DBL_BIT] = wait_count_doubler;
      default: rd_mux = EWSP_ZERO16;
    endcase
  end

  // read data registered one cycle after the read strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mmr_rdata <= EWSP_ZERO16;
    end else if (mmr_rd) begin
      mmr_rdata <= rd_mux;
    end
  end

  // gated-clock enable for the wait generator
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wsg_clk_on <= 1'b1;
    end else begin
      wsg_clk_on <= !fields_zero;
    end
  end

  // address formation, internal decode and wait selection for a new request
  always_comb begin
    next_xaddr = {EWSP_ZERO4, acc_addr};
    next_internal = 1'b0;
    case (acc_space)
      EWSP_SP_PROG: begin
        if (acc_table) begin
          next_xaddr = acc_xaddr;
        end else begin
          next_xaddr = {prog_page, acc_addr};
        end
        // overlay puts RAM in the low 16K of every page
        next_internal = ram_overlay_bit && (next_xaddr[15:14] == EWSP_OVL_TOP);
      end
      EWSP_SP_DATA: next_internal = (acc_addr < EWSP_DATA_INT_LIM);
      default: next_internal = 1'b0;
    endcase
    // field choice per range, then optional doubling
    next_waits = ewsp_waits(wait_sel, wait_count_doubler, acc_space,
                            next_xaddr[EWSP_HALF_BIT]);
  end

  // access sequencer: internal answers next cycle, external waits it out
  always_comb begin
    next_state = state;
    case (state)
      EWSP_IDLE: begin
        if (acc_req) begin
          next_state = next_internal ? EWSP_INT : EWSP_WAIT;
        end
      end
      EWSP_WAIT: begin
        // both the count and the ready pin must agree
        if (expired && ready_s) begin
          next_state = EWSP_IDLE;
        end
      end
      EWSP_INT: next_state = EWSP_IDLE;
      default: next_state = EWSP_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= EWSP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // external bus pins; strobe held low through the whole stretched cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_addr <= {EWSP_ZERO4, EWSP_ZERO16};
      ext_space <= EWSP_SP_PROG;
      ext_strb_n <= 1'b1;
      ext_we_n <= 1'b1;
    end else if (take && !next_internal) begin
      ext_addr <= next_xaddr;
      ext_space <= acc_space;
      ext_strb_n <= 1'b0;
      ext_we_n <= !acc_we;
    end else if (state == EWSP_WAIT && expired && ready_s) begin
      ext_strb_n <= 1'b1;
      ext_we_n <= 1'b1;
    end
  end

  // handshake back to the core
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_busy <= 1'b0;
      acc_done <= 1'b0;
      acc_internal <= 1'b0;
    end else begin
      acc_busy <= (next_state != EWSP_IDLE);
      acc_done <= (state == EWSP_INT) || (state == EWSP_WAIT && expired && ready_s);
      acc_internal <= (state == EWSP_INT);
    end
  end

  // checking helpers: strobe length and expected waits of the current access
  logic [5:0] strb_len;
  logic [EWSP_CW-1:0] exp_waits;
  logic rd_ctl_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      strb_len <= 6'h00;
      exp_waits <= EWSP_ZERO4;
      rd_ctl_q <= 1'b0;
    end else begin
      rd_ctl_q <= mmr_rd && (mmr_addr == EWSP_WCTL_OFS);
      if (take) begin
        exp_waits <= next_waits;
        strb_len <= 6'h00;
      end else if (!ext_strb_n && strb_len != 6'h3F) begin
        strb_len <= strb_len + 6'h01;
      end
    end
  end

  // base count recovered from the selected waits, so field checks stay independent
  logic [EWSP_FW-1:0] sel_base;
  always_comb begin
    sel_base = next_waits[EWSP_FW-1:0];
    if (wait_count_doubler) begin
      sel_base = next_waits[EWSP_CW-1:1];
    end
  end

  a_wait_max_sel: assert property (
    @(posedge clk) disable iff (sys_rst)
    take |-> (next_waits <= EWSP_WAIT_MAX) &&
      (wait_count_doubler ? !next_waits[0] : !next_waits[EWSP_CW-1]))
    else $error("wait count above limit or wrongly doubled");

  a_strobe_stretch: assert property (
    @(posedge clk) disable iff (sys_rst)
    (acc_done && !acc_internal) |-> (strb_len >= {2'b00, exp_waits}))
    else $error("external strobe shorter than programmed waits");

  a_done_ready: assert property (
    @(posedge clk) disable iff (sys_rst)
    (acc_done && !acc_internal) |-> $past(ready_s) && $rose(ext_strb_n))
    else $error("external access ended without ready");

  a_gate_frozen: assert property (
    @(posedge clk) disable iff (sys_rst)
    (!wsg_clk_on && state == EWSP_WAIT && !take) |=> $stable(expired))
    else $error("wait counter moved with its clock gated off");

  a_page_hold: assert property (
    @(posedge clk) disable iff (sys_rst)
    (!far_load && !(mmr_wr && mmr_addr == EWSP_PAGE_OFS)) |=> $stable(prog_page))
    else $error("page register changed without a far transfer");

  a_page_far: assert property (
    @(posedge clk) disable iff (sys_rst)
    (far_load ##1 take && acc_space == EWSP_SP_PROG && !acc_table && !next_internal)
      |=> ext_addr[EWSP_XAW-1:EWSP_AW] == $past(far_page, 2))
    else $error("program address not on the far page");

  a_ctl_reserved: assert property (
    @(posedge clk) disable iff (sys_rst)
    rd_ctl_q |-> (mmr_rdata[15:1] == 15'h0000))
    else $error("reserved control bits read nonzero");

  a_overlay_int: assert property (
    @(posedge clk) disable iff (sys_rst)
    (take && acc_space == EWSP_SP_PROG && ram_overlay_bit &&
     next_xaddr[15:14] == EWSP_OVL_TOP) |=> ##1 (acc_done && acc_internal && ext_strb_n))
    else $error("overlay access went to the external bus");

  a_table_addr: assert property (
    @(posedge clk) disable iff (sys_rst)
    (take && acc_space == EWSP_SP_PROG && acc_table && !next_internal)
      |=> (ext_addr == $past(acc_xaddr)) && !ext_strb_n)
    else $error("table access address not from accumulator");

  a_busy_done: assert property (
    @(posedge clk) disable iff (sys_rst)
    acc_done |-> !acc_busy)
    else $error("busy still high at access end");

  a_strobe_held: assert property (
    @(posedge clk) disable iff (sys_rst)
    (state == EWSP_WAIT && !(expired && ready_s)) |=> !ext_strb_n && acc_busy)
    else $error("strobe released before the access ended");

  a_io_field: assert property (
    @(posedge clk) disable iff (sys_rst)
    (take && acc_space == EWSP_SP_IO)
      |-> (sel_base == wait_sel[EWSP_IO_LSB +: EWSP_FW]))
    else $error("I/O access not timed by its own field");

  a_dhi_field: assert property (
    @(posedge clk) disable iff (sys_rst)
    (take && acc_space == EWSP_SP_DATA && acc_addr[EWSP_HALF_BIT])
      |-> (sel_base == wait_sel[EWSP_DHI_LSB +: EWSP_FW]))
    else $error("upper data access not timed by its own field");

  a_dlo_field: assert property (
    @(posedge clk) disable iff (sys_rst)
    (take && acc_space == EWSP_SP_DATA && !acc_addr[EWSP_HALF_BIT])
      |-> (sel_base == wait_sel[EWSP_DLO_LSB +: EWSP_FW]))
    else $error("lower data access not timed by its own field");

  a_phi_field: assert property (
    @(posedge clk) disable iff (sys_rst)
    (take && acc_space == EWSP_SP_PROG && !wait_sel[EWSP_XPA_BIT] && next_xaddr[EWSP_HALF_BIT])
      |-> (sel_base == wait_sel[EWSP_PHI_LSB +: EWSP_FW]))
    else $error("upper program access not timed by its own field");

  a_plo_field: assert property (
    @(posedge clk) disable iff (sys_rst)
    (take && acc_space == EWSP_SP_PROG && !wait_sel[EWSP_XPA_BIT] && !next_xaddr[EWSP_HALF_BIT])
      |-> (sel_base == wait_sel[EWSP_PLO_LSB +: EWSP_FW]))
    else $error("lower program access not timed by its own field");

  a_xpa_field: assert property (
    @(posedge clk) disable iff (sys_rst)
    (take && acc_space == EWSP_SP_PROG && wait_sel[EWSP_XPA_BIT])
      |-> (sel_base == wait_sel[EWSP_PLO_LSB +: EWSP_FW]))
    else $error("extended program access not timed by the low field");

  a_data_int: assert property (
    @(posedge clk) disable iff (sys_rst)
    (take && acc_space == EWSP_SP_DATA && acc_addr < EWSP_DATA_INT_LIM)
      |=> ext_strb_n ##1 (acc_done && acc_internal))
    else $error("on-chip data access went to the external bus");
endmodule : ewsp_top

// File: sim/ewsp_ext_dev.sv
`timescale 1ns/1ps
module ewsp_ext_dev (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ext_strb_n,
  input wire logic [3:0] hold,
  output logic ext_ready
);
  logic [3:0] cnt;
  // cycles since the strobe fell; a slow device keeps ready low while it counts
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 4'h0;
    end else if (ext_strb_n) begin
      cnt <= 4'h0;
    end else if (cnt != 4'hF) begin
      cnt <= cnt + 4'h1;
    end
  end
  // hold of zero answers at once; a slow device shows ready low while idle
  assign ext_ready = (cnt >= hold);
endmodule : ewsp_ext_dev

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import ewsp_pkg::*;
  logic clk, sys_rst, mmr_wr, mmr_rd, ram_overlay_bit, far_load, acc_req, acc_we, acc_table;
  logic [15:0] mmr_addr, mmr_wdata, mmr_rdata, acc_addr, rd;
  logic [3:0] far_page, prog_page, hold;
  logic [19:0] acc_xaddr, ext_addr;
  ewsp_space_e acc_space, ext_space, spc;
  logic bsy, wen;
  logic acc_busy, acc_done, acc_internal, ext_strb_n, ext_we_n, ext_ready, wsg_clk_on, intl;
  int num_errors, checks_done, n;
  ewsp_space_e sp[5] = '{EWSP_SP_IO, EWSP_SP_DATA, EWSP_SP_DATA, EWSP_SP_PROG, EWSP_SP_PROG};
  logic [15:0] ad[5] = '{16'h1234, 16'h9000, 16'h5000, 16'h9000, 16'h4000};
  int base[5] = '{1, 2, 3, 4, 5};

  ewsp_top ewsp_top_inst (.clk, .sys_rst, .mmr_addr, .mmr_wr, .mmr_rd, .mmr_wdata, .mmr_rdata,
    .ram_overlay_bit, .far_load, .far_page, .acc_req, .acc_space, .acc_addr, .acc_we,
    .acc_table, .acc_xaddr, .acc_busy, .acc_done, .acc_internal, .prog_page, .ext_addr,
    .ext_space, .ext_strb_n, .ext_we_n, .ext_ready, .wsg_clk_on);
  ewsp_ext_dev ewsp_ext_dev_inst (.clk, .sys_rst, .ext_strb_n, .hold, .ext_ready);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // register strobes are one cycle wide, entered just after an edge; an idle edge follows
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    mmr_addr = a;
    mmr_wdata = d;
    mmr_wr = 1'b1;
    @(posedge clk);
    #1 mmr_wr = 1'b0;
    @(posedge clk);
    #1;
  endtask : wr

  task automatic rdr(input logic [15:0] a, output logic [15:0] d);
    mmr_addr = a;
    mmr_rd = 1'b1;
    @(posedge clk);
    #1 mmr_rd = 1'b0;
    d = mmr_rdata;
    @(posedge clk);
    #1;
  endtask : rdr

  // n counts edges from the take edge to the one that raises acc_done
  task automatic acc(input ewsp_space_e s, input logic [15:0] a, input logic tb);
    acc_space = s;
    acc_addr = a;
    acc_table = tb;
    acc_req = 1'b1;
    n = 0;
    @(posedge clk);
    #1 acc_req = 1'b0;
    bsy = acc_busy;
    wen = ext_we_n;
    spc = ext_space;
    while (acc_done !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1 n++;
    end
    intl = acc_internal;
  endtask : acc

  task automatic t_reset();
    rdr(EWSP_PAGE_OFS, rd);
    chk("page", 20'h0, rd);
    rdr(EWSP_WSEL_OFS, rd);
    chk("wsel", 20'h7FFF, rd);
    rdr(EWSP_WCTL_OFS, rd);
    chk("wctl", 20'h0, rd);
    acc(EWSP_SP_DATA, 16'h8000, 1'b0);
    chk("reset waits", 20'd8, n);
    $display("test reset done");
  endtask : t_reset

  task automatic t_fields();
    wr(EWSP_WSEL_OFS, 16'h14E5);
    for (int d = 0; d < 2; d++) begin
      wr(EWSP_WCTL_OFS, d ? 16'hFFFF : 16'h0000);
      for (int i = 0; i < 5; i++) begin
        acc(sp[i], ad[i], 1'b0);
        chk("range waits", 20'((base[i] << d) + 1), n);
      end
    end
    rdr(EWSP_WCTL_OFS, rd);
    chk("wctl reserved", 20'h1, rd);
    wr(EWSP_WSEL_OFS, 16'h94E5);
    acc(EWSP_SP_PROG, 16'h9000, 1'b0);
    chk("xpa waits", 20'd11, n);
    wr(EWSP_WSEL_OFS, 16'h7FFF);
    acc(EWSP_SP_IO, 16'hFFFF, 1'b0);
    chk("max waits", 20'd15, n);
    wr(EWSP_WCTL_OFS, 16'h0000);
    $display("test fields done");
  endtask : t_fields

  task automatic t_zero();
    wr(EWSP_WSEL_OFS, 16'h0000);
    repeat (2) @(posedge clk);
    #1 chk("gate off", 20'h0, wsg_clk_on);
    acc(EWSP_SP_IO, 16'h0010, 1'b0);
    chk("zero waits", 20'd1, n);
    wr(EWSP_WSEL_OFS, 16'h0001);
    repeat (2) @(posedge clk);
    #1 chk("gate on", 20'h1, wsg_clk_on);
    $display("test zero done");
  endtask : t_zero

  task automatic t_page();
    wr(EWSP_PAGE_OFS, 16'hFFFF);
    rdr(EWSP_PAGE_OFS, rd);
    chk("page width", 20'hF, rd);
    far_page = 4'h3;
    far_load = 1'b1;
    @(posedge clk);
    #1 far_load = 1'b0;
    chk("far page", 20'h3, prog_page);
    acc(EWSP_SP_PROG, 16'h9000, 1'b0);
    chk("paged addr", 20'h39000, ext_addr);
    acc_xaddr = 20'hABCDE;
    acc(EWSP_SP_PROG, 16'h0000, 1'b1);
    chk("table addr", 20'hABCDE, ext_addr);
    chk("page kept", 20'h3, prog_page);
    acc_we = 1'b1;
    acc(EWSP_SP_IO, 16'h0040, 1'b0);
    acc_we = 1'b0;
    chk("write busy", 20'h1, bsy);
    chk("write strobe", 20'h0, wen);
    chk("io space", 20'(EWSP_SP_IO), 20'(spc));
    chk("write end", 20'h1, ext_we_n);
    $display("test page done");
  endtask : t_page

  task automatic t_ovl();
    ram_overlay_bit = 1'b1;
    acc(EWSP_SP_PROG, 16'h1000, 1'b0);
    chk("ovl on", 20'h1, intl);
    ram_overlay_bit = 1'b0;
    acc(EWSP_SP_PROG, 16'h1000, 1'b0);
    chk("ovl off", 20'h0, intl);
    acc(EWSP_SP_DATA, 16'h0100, 1'b0);
    chk("data ram", 20'h1, intl);
    acc(EWSP_SP_DATA, 16'h4000, 1'b0);
    chk("data ext", 20'h0, intl);
    $display("test overlay done");
  endtask : t_ovl

  // slow device: done must wait for ready past the one programmed wait
  task automatic t_ready();
    wr(EWSP_WSEL_OFS, 16'h1000);
    hold = 4'h6;
    acc(EWSP_SP_IO, 16'h0040, 1'b0);
    chk("ready wait", 20'h1, 20'(n >= 9 && n <= 11));
    hold = 4'h0;
    $display("test ready done");
  endtask : t_ready

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  initial begin
    {sys_rst, mmr_wr, mmr_rd, ram_overlay_bit, far_load, acc_req, acc_we, acc_table} = 8'h80;
    mmr_addr = 16'h0000;
    mmr_wdata = 16'h0000;
    acc_addr = 16'h0000;
    far_page = 4'h0;
    hold = 4'h0;
    acc_xaddr = 20'h00000;
    acc_space = EWSP_SP_PROG;
    num_errors = 0;
    checks_done = 0;
    repeat (4) @(posedge clk);
    #1 sys_rst = 1'b0;
    t_reset();
    t_fields();
    t_zero();
    t_page();
    t_ovl();
    t_ready();
    results();
  end

  // the tests need well under a thousand cycles; twenty thousand means a hang
  initial begin
    #(25 * 20000);
    num_errors++;
    results();
  end
endmodule : testbench
